/* File: core/ssf_pkg.sv */
// Constants, frame layout and shared types of the star SPI frame slave.
// Assumes one SPI master per bus and up to 26 slaves on one chip-select.
// How it works
// - Three three-level straps give 26 IDs; all-ground is reserved for general call.
// - ID is base-3 of the straps: ground 0, serial-in 1, supply 2.
// - Call type 01 is one device, 10 is all or cluster, others invalid; the code takes 10 only with ID 0, as general call.
// - Clock and input pull down, chip-select pulls up, all nominally 100k.
// - Each termination has its own enable bit; one engages, zero releases it.
// - Frame: flag 31, call 30:29, ID 28:24, address 22:16, data 15:3, CRC 2:0.
// - CRC3 over bits 31 to 3, polynomial x^3+x+1, start value zero.
// - A frame is accepted only when the computed CRC matches bits 2:0.
// - Write reply to an individual call: low from chip-select fall, eight zeros, then 24-bit log; general call replies all zeros.
// - After the eighth rising edge only the addressed device keeps driving output.
// - Clocks beyond the frame send zeros and set the clock error.
// - Write needs 32 clocks, good CRC, writable address; else matching error flag.
// - A qualified write executes, updates the register and logs success.
// - An unqualified write sets sticky error and diagnostic bit, logs failure.
// - Write qualification looks at the last 32 bits before chip-select rises.
// - Read frame has flag one, individual call and zero data bits.
// - The seven address bits pick one of 128 registers.
// - Read qualification looks at the last 32 bits received, like a write.
// - Input sampled on rising clock while selected; execution on chip-select rise.
// - Output released while deselected; output bits change on falling clock.
// - Clock stalled over 256 us with chip-select low sets the clock error.
// - Read reply: eight zeros, sticky error, seven status, 13 data, CRC3.
package ssf_pkg;

    localparam int          CNT_W       = 6;
    localparam logic [5:0]  HDR_CNT     = 6'h08;
    localparam logic [5:0]  ADDR_CNT    = 6'h10;
    localparam logic [5:0]  FRAME_CNT   = 6'h20;
    localparam logic [5:0]  CNT_OVER    = 6'h21;
    localparam logic [1:0]  CALL_SINGLE = 2'h1;
    localparam logic [1:0]  CALL_GROUP  = 2'h2;
    localparam logic [2:0]  CRC_POLY    = 3'h3;
    localparam logic [2:0]  CRC_INIT    = 3'h0;
    localparam logic [4:0]  GENERAL_ID  = 5'h00;
    localparam logic [4:0]  ID_MAX      = 5'h1A;
    localparam logic [4:0]  TRIT_HI     = 5'h09;
    localparam logic [4:0]  TRIT_MID    = 5'h03;
    localparam logic [1:0]  LVL_BAD     = 2'h3;
    localparam logic [2:0]  SETTLE      = 3'h7;
    localparam int          REG_COUNT   = 128;
    localparam logic [6:0]  WR_LO       = 7'h01;
    localparam logic [6:0]  WR_HI       = 7'h3F;
    localparam logic [6:0]  TERM_ADDR   = 7'h01;
    localparam logic [2:0]  TERM_RESET  = 3'h7;
    localparam int          TERM_CLK    = 0;
    localparam int          TERM_SDI    = 1;
    localparam int          TERM_CS     = 2;
    localparam int          TIMEOUT_US  = 256;
    localparam int          CLK_MHZ     = 20;
    localparam int          TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
    localparam int          TMO_W       = 13;

    // Incoming frame as it lies in the shift word.
    typedef struct packed {
        logic        read_not_write_flag;
        logic [1:0]  call;
        logic [4:0]  target_id;
        logic        pad;
        logic [6:0]  addr;
        logic [12:0] data;
        logic [2:0]  in_check_bits;
    } ssf_frame_t;

    typedef struct packed {
        logic clk_err;
        logic crc_err;
        logic wr_err;
        logic rd_err;
    } ssf_diag_t;

    // Transaction log entry sent back during individual-call writes.
    typedef struct packed {
        logic        ok;
        logic        rd;
        logic [1:0]  call;
        logic [6:0]  addr;
        logic [12:0] data;
    } ssf_log_t;

    // Serial CRC3, message most significant bit first; leading zeros are neutral.
    function automatic logic [2:0] crc3(input logic [28:0] msg);
        logic [2:0] c;
        logic       fb;
        c = CRC_INIT;
        for (int i = 28; i >= 0; i--) begin
            fb = c[2] ^ msg[i];
            c  = {c[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
        end
        return c;
    endfunction : crc3

endpackage : ssf_pkg

/* File: core/ssf_sync.sv */
// Three-stage synchroniser; a bit changes once stages two and three agree.
// Assumes the input is a level from another clock domain or a pin.
`timescale 1ns/1ps
`default_nettype none
module ssf_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] agree;
    logic [W-1:0] next_q;

    // The first stage feeds only the second, so no logic sees a metastable value.
    assign agree  = ~(s2 ^ s3);
    assign next_q = (agree & s3) | (~agree & q);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            q  <= INIT;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end

endmodule : ssf_sync
`default_nettype wire

/* File: core/ssf_strap_id.sv */
// Resolves the own device ID from three three-level strap sensors.
// Assumes each sensor reports 0 ground, 1 tied to serial input, 2 supply.
`timescale 1ns/1ps
`default_nettype none
module ssf_strap_id (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] id_strap_hi,
    input  wire logic [1:0] id_strap_mid,
    input  wire logic [1:0] id_strap_lo,
    output logic [4:0]      own_id,
    output logic            id_valid
);

    logic [5:0] lvl;
    logic [2:0] settle;
    logic [4:0] next_id;
    logic       next_valid;

    ssf_sync #(.W(6), .INIT(6'h00)) u_lvl_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({id_strap_hi, id_strap_mid, id_strap_lo}),
        .q       (lvl)
    );

    // Base-3 weighting, first strap most significant.
    assign next_id = 5'(({3'h0, lvl[5:4]} * ssf_pkg::TRIT_HI)
                      + ({3'h0, lvl[3:2]} * ssf_pkg::TRIT_MID)
                      + {3'h0, lvl[1:0]});
    // All-ground is the general-call ID and an unknown level is no ID at all.
    assign next_valid = (next_id != ssf_pkg::GENERAL_ID)
                     && (lvl[5:4] != ssf_pkg::LVL_BAD)
                     && (lvl[3:2] != ssf_pkg::LVL_BAD)
                     && (lvl[1:0] != ssf_pkg::LVL_BAD);

    // Straps are caught after reset release, once the synchroniser has filled.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            settle   <= 3'h0;
            own_id   <= 5'h00;
            id_valid <= 1'b0;
        end else if (settle != ssf_pkg::SETTLE) begin
            settle   <= settle + 3'h1;
            own_id   <= next_id;
            id_valid <= next_valid;
        end
    end

    a_id_range: assert property (@(posedge clk) disable iff (!reset_n)
        id_valid |-> (own_id != 5'h00) && (own_id <= ssf_pkg::ID_MAX))
        else $error("valid own ID outside 1 to 26");

endmodule : ssf_strap_id
`default_nettype wire

/* File: core/ssf_frame_slave.sv */
// Star SPI frame slave: link shifter and output driver, frame executor.
// Assumes serial_clock stands still while chip_select_n is high.
`timescale 1ns/1ps
`default_nettype none
module ssf_frame_slave #(
    parameter int TIMEOUT_CYC = ssf_pkg::TIMEOUT_CYCLES
) (
    input  wire logic           clk,
    input  wire logic           reset_n,
    input  wire logic           serial_clock,
    input  wire logic           chip_select_n,
    input  wire logic           serial_in,
    output logic                serial_out,
    output logic                serial_out_oe,
    input  wire logic [1:0]     id_strap_hi,
    input  wire logic [1:0]     id_strap_mid,
    input  wire logic [1:0]     id_strap_lo,
    input  wire logic [6:0]     general_status,
    input  wire logic           err_clear,
    output logic                term_en_clock,
    output logic                term_en_input,
    output logic                term_en_select,
    output logic                wr_strobe,
    output logic                rd_strobe,
    output logic [6:0]          exec_addr,
    output logic [12:0]         wr_data,
    output logic                spi_err,
    output var ssf_pkg::ssf_diag_t diag,
    output logic [4:0]          own_id,
    output logic                id_valid
);

    logic                       armed;
    logic [2:0]                 act_div;
    logic [31:0]                shift;
    logic [ssf_pkg::CNT_W-1:0]  count;
    logic [7:0]                 hdr;
    logic [6:0]                 rd_addr;
    logic [31:0]                next_shift;
    logic [ssf_pkg::CNT_W-1:0]  next_count;
    logic                       sout;
    logic                       keep;
    logic                       next_sout;
    logic                       next_keep;
    logic                       sel;
    logic [12:0]                rd_data;
    logic [20:0]                rd_body;
    logic [31:0]                resp;
    logic [12:0]                mem [ssf_pkg::REG_COUNT];
    logic [2:0]                 term;
    logic [6:0]                 status_hold;
    logic                       err_hold;
    ssf_pkg::ssf_log_t          log_word;

    // Link side, rising edges. armed drops while deselected, so the first edge
    // of a frame restarts the count and the word.
    assign next_shift = armed ? {shift[30:0], serial_in} : {31'h0, serial_in};
    assign next_count = !armed ? 6'h01
                      : (count == ssf_pkg::CNT_OVER) ? count
                      : ssf_pkg::CNT_W'(count + 6'h01);

    always_ff @(posedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            armed   <= 1'b0;
            act_div <= 3'h0;
        end else begin
            armed   <= 1'b1;
            act_div <= act_div + 3'h1; // Bit 2 stands four link periods, slow enough to sync.
        end
    end

    // The word and count survive the frame end; the executor reads them while
    // the link clock stands still, which is what makes that crossing safe.
    always_ff @(posedge serial_clock) begin
        shift <= next_shift;
        count <= next_count;
        if (next_count == ssf_pkg::HDR_CNT) begin
            hdr <= next_shift[7:0];
        end
        if (next_count == ssf_pkg::ADDR_CNT) begin
            rd_addr <= next_shift[6:0];
        end
    end

    // Reply word. Status and error are snapshots frozen while selected.
    assign rd_data = (rd_addr == ssf_pkg::TERM_ADDR) ? {10'h000, term} : mem[rd_addr];
    assign rd_body = {err_hold, status_hold, rd_data};
    assign resp    = (hdr[6:5] != ssf_pkg::CALL_SINGLE) ? 32'h0000_0000
                   : hdr[7] ? {8'h00, rd_body, ssf_pkg::crc3({8'h00, rd_body})}
                   : {8'h00, log_word};

    // Only individual calls to our ID, or a general call, keep the line.
    assign sel = ((hdr[6:5] == ssf_pkg::CALL_SINGLE) && (hdr[4:0] == own_id) && id_valid)
              || ((hdr[6:5] == ssf_pkg::CALL_GROUP) && (hdr[4:0] == ssf_pkg::GENERAL_ID));
    assign next_keep = (armed && (count == ssf_pkg::HDR_CNT)) ? sel : keep;
    assign next_sout = (armed && (count < ssf_pkg::FRAME_CNT)) ? resp[~count[4:0]]
                     : 1'b0;

    // Falling edges move the output; deselect forces it low and claimed.
    always_ff @(negedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            sout <= 1'b0;
            keep <= 1'b1;
        end else begin
            sout <= next_sout;
            keep <= next_keep;
        end
    end

    assign serial_out = sout;
    // The enable follows the pin at once so the line is driven as soon as
    // chip-select falls and released the moment it rises.
    assign serial_out_oe = keep & ~chip_select_n;

    // System side.
    logic                       cs_s;
    logic                       cs_q;
    logic                       act_s;
    logic                       act_q;
    logic                       act_edge;
    logic                       frame_rise;
    logic                       idle;
    logic [ssf_pkg::TMO_W-1:0]  tmo_cnt;
    logic                       tmo_hit;
    logic                       tmo_seen;
    logic                       frame_act;

    ssf_sync #(.W(1), .INIT(1'b1)) u_cs_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (chip_select_n),
        .q       (cs_s)
    );

    ssf_sync #(.W(1), .INIT(1'b0)) u_act_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (act_div[2]),
        .q       (act_s)
    );

    ssf_strap_id u_strap (
        .clk          (clk),
        .reset_n      (reset_n),
        .id_strap_hi  (id_strap_hi),
        .id_strap_mid (id_strap_mid),
        .id_strap_lo  (id_strap_lo),
        .own_id       (own_id),
        .id_valid     (id_valid)
    );

    assign act_edge   = act_s ^ act_q;
    assign frame_rise = cs_s & ~cs_q;
    assign idle       = cs_s & cs_q;
    assign tmo_hit    = (tmo_cnt == ssf_pkg::TMO_W'(TIMEOUT_CYC));

    // Stall watch: restarted by every fourth rising link edge while selected.
    always_ff @(posedge clk) begin
        if (!reset_n || idle || act_edge) begin
            tmo_cnt <= '0;
        end else if (!tmo_hit) begin
            tmo_cnt <= ssf_pkg::TMO_W'(tmo_cnt + 1'b1);
        end
    end

    // A chip-select pulse with no clock edges carries no frame and is ignored.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cs_q      <= 1'b1;
            act_q     <= 1'b0;
            tmo_seen  <= 1'b0;
            frame_act <= 1'b0;
        end else begin
            cs_q      <= cs_s;
            act_q     <= act_s;
            tmo_seen  <= !idle && (tmo_seen || tmo_hit);
            frame_act <= !idle && (frame_act || (act_edge && !cs_s));
        end
    end

    // Frame decode, read only in the cycle where the synchronised chip-select is first seen high.
    ssf_pkg::ssf_frame_t fr;
    logic                call_ok;
    logic                addressed;
    logic                clk_bad;
    logic                crc_bad;
    logic                cmd_bad;
    logic                exec;
    logic                qual;
    logic                fail;
    logic [3:0]          diag_set;
    logic [3:0]          next_diag;

    assign fr        = ssf_pkg::ssf_frame_t'(shift);
    assign call_ok   = (fr.call == ssf_pkg::CALL_SINGLE) || (fr.call == ssf_pkg::CALL_GROUP);
    assign addressed = !call_ok
                    || ((fr.call == ssf_pkg::CALL_SINGLE) && (fr.target_id == own_id) && id_valid)
                    || ((fr.call == ssf_pkg::CALL_GROUP) && (fr.target_id == ssf_pkg::GENERAL_ID));
    assign clk_bad   = (count != ssf_pkg::FRAME_CNT) || tmo_seen;
    assign crc_bad   = ssf_pkg::crc3(shift[31:3]) != fr.in_check_bits;
    // Reads are judged on zero data bits and an individual call type.
    assign cmd_bad   = fr.read_not_write_flag
                     ? ((fr.data != 13'h0000) || (fr.call != ssf_pkg::CALL_SINGLE))
                     : ((fr.addr < ssf_pkg::WR_LO) || (fr.addr > ssf_pkg::WR_HI) || !call_ok);
    assign exec      = frame_rise && frame_act && addressed;
    assign qual      = exec && !clk_bad && !crc_bad && !cmd_bad;
    assign fail      = exec && !qual;
    assign diag_set  = {(fail && clk_bad) || tmo_hit,
                        fail && crc_bad,
                        fail && cmd_bad && !fr.read_not_write_flag,
                        fail && cmd_bad && fr.read_not_write_flag};
    // A new error wins over a clear in the same cycle.
    assign next_diag = diag_set | (diag & {4{~err_clear}});

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_strobe <= 1'b0;
            rd_strobe <= 1'b0;
            exec_addr <= 7'h00;
            wr_data   <= 13'h0000;
            spi_err   <= 1'b0;
            diag      <= '0;
            log_word  <= '0;
        end else begin
            wr_strobe <= qual && !fr.read_not_write_flag;
            rd_strobe <= qual && fr.read_not_write_flag;
            spi_err   <= fail || (spi_err && !err_clear);
            diag      <= ssf_pkg::ssf_diag_t'(next_diag);
            if (exec) begin
                exec_addr <= fr.addr;
                wr_data   <= fr.data;
                log_word  <= {qual, fr.read_not_write_flag, fr.call, fr.addr, fr.data};
            end
        end
    end

    // Register array and terminations; written only after a frame has ended.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < ssf_pkg::REG_COUNT; i++) begin
                mem[i] <= 13'h0000;
            end
            term <= ssf_pkg::TERM_RESET;
        end else if (qual && !fr.read_not_write_flag) begin
            mem[fr.addr] <= fr.data;
            if (fr.addr == ssf_pkg::TERM_ADDR) begin
                term <= fr.data[2:0];
            end
        end
    end

    // Snapshots feed the link; they move only while deselected.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_hold <= 7'h00;
            err_hold    <= 1'b0;
        end else if (idle) begin
            status_hold <= general_status;
            err_hold    <= spi_err;
        end
    end

    assign term_en_clock  = term[ssf_pkg::TERM_CLK];
    assign term_en_input  = term[ssf_pkg::TERM_SDI];
    assign term_en_select = term[ssf_pkg::TERM_CS];

    // Checks on the system side.
    sequence s_bad_crc;
        exec && crc_bad;
    endsequence

    a_crc_gate: assert property (@(posedge clk) disable iff (!reset_n)
        s_bad_crc |=> !wr_strobe && !rd_strobe && spi_err && diag.crc_err)
        else $error("frame with bad CRC was executed");

    a_clock_count: assert property (@(posedge clk) disable iff (!reset_n)
        (exec && (count != ssf_pkg::FRAME_CNT)) |=> diag.clk_err && !wr_strobe)
        else $error("frame without 32 clocks was not refused");

    a_write_exec: assert property (@(posedge clk) disable iff (!reset_n)
        (qual && !fr.read_not_write_flag) |=> wr_strobe && log_word.ok
            && (exec_addr == $past(fr.addr)) && (wr_data == $past(fr.data)))
        else $error("qualified write not carried out");

    a_sticky_err: assert property (@(posedge clk) disable iff (!reset_n)
        (spi_err && !err_clear) |=> spi_err [*1] ##0 $stable(spi_err))
        else $error("sticky error dropped without a clear");

    a_invalid_call: assert property (@(posedge clk) disable iff (!reset_n)
        (exec && !call_ok) |=> !wr_strobe && spi_err && !log_word.ok)
        else $error("invalid call type was accepted");

    a_timeout_flag: assert property (@(posedge clk) disable iff (!reset_n)
        (!cs_s && !act_edge && (tmo_cnt == ssf_pkg::TMO_W'(TIMEOUT_CYC - 1)))
            |=> tmo_hit ##1 diag.clk_err)
        else $error("stalled link clock did not raise clock error");

    // Checks on the link side.
    a_shift_align: assert property (@(posedge serial_clock) disable iff (chip_select_n)
        !armed |=> (count == 6'h01))
        else $error("frame did not restart at bit 31");

    a_head_zero: assert property (@(negedge serial_clock) disable iff (chip_select_n)
        (armed && (count < ssf_pkg::HDR_CNT)) |=> !serial_out)
        else $error("header bit of reply not zero");

    a_extra_zero: assert property (@(negedge serial_clock) disable iff (chip_select_n)
        (armed && (count >= ssf_pkg::FRAME_CNT)) |=> !serial_out)
        else $error("bit beyond the frame not zero");

    a_release_line: assert property (@(negedge serial_clock) disable iff (chip_select_n)
        (armed && (count == ssf_pkg::HDR_CNT) && !sel) |=> !serial_out_oe)
        else $error("unaddressed slave still drives the output");

endmodule : ssf_frame_slave
`default_nettype wire

/* File: testbench/ssf_master_model.sv */
// SPI master model in mode 0: frames of any bit count, with an optional stall.
// Assumes the slave samples on rising serial_clock and shifts on falling.
`timescale 1ns/1ps
`default_nettype none
module ssf_master_model (
    output logic      serial_clock,
    output logic      chip_select_n,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    // A released line shows the inverse, so a stale bit can never pass as data.
    wire line = serial_out_oe ? serial_out : ~serial_out;
    // Idle bus: clock low and still, chip-select high, input at its pulldown.
    initial begin
        serial_clock = 1'b0;
        serial_in = 1'b0;
        // Raised after time zero so the slave's asynchronous clear sees a real edge.
        #1 chip_select_n = 1'b1;
    end
    // Bits change while the clock is low and are sampled at each rise.
    task automatic xfer(input logic [31:0] f, input int n, input int stall,
                        output logic [31:0] r, output logic oe_mid);
        r = '0;
        oe_mid = 1'b1;
        chip_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = (i < 32) ? f[i] : 1'b0;
            #24;
            if (i == 8 && stall > 0) #(stall);
            serial_clock = 1'b1;
            r = {r[30:0], line};
            if (i == 16) oe_mid = serial_out_oe;
            #24;
            serial_clock = 1'b0;
        end
        #24;
        chip_select_n = 1'b1;
        serial_in = 1'b0; // Released input falls to its pulldown.
        #500;
    endtask : xfer
endmodule : ssf_master_model
`default_nettype wire

/* File: testbench/ssf_frame_slave_tb_top.sv */
// Self-checking bench of the frame slave: writes, reads, call types, errors.
// Assumes the master model owns the link pins and the bench the rest.
`timescale 1ns/1ps
`default_nettype none
module ssf_frame_slave_tb_top;
    localparam logic [4:0] ID = 5'h0B; // Straps 1,0,2 read in base 3.
    logic clk = 1'b0, reset_n = 1'b0, err_clear = 1'b0, oe_mid;
    wire serial_clock, chip_select_n, serial_in, serial_out, serial_out_oe;
    wire wr_strobe, rd_strobe, spi_err, id_valid, term_en_clock, term_en_input, term_en_select;
    wire [6:0] exec_addr;
    wire [12:0] wr_data;
    wire [4:0] own_id;
    ssf_pkg::ssf_diag_t diag;
    logic [31:0] rep;
    logic [31:0] ef [6];
    logic [3:0] ed [6];
    int en [6], es [6];
    int fails = 0, tests_run = 0, wr_cnt = 0, rd_cnt = 0, w0, r0;
    always #25 clk = ~clk;
    // Strobes last one clock, so they are counted rather than sampled later.
    always @(posedge clk) begin
        if (wr_strobe === 1'b1) wr_cnt++;
        if (rd_strobe === 1'b1) rd_cnt++;
    end
    ssf_frame_slave #(.TIMEOUT_CYC(200)) dut (
        .clk, .reset_n, .serial_clock, .chip_select_n, .serial_in, .serial_out, .serial_out_oe,
        .id_strap_hi(2'h1), .id_strap_mid(2'h0), .id_strap_lo(2'h2), .general_status(7'h5A),
        .err_clear, .term_en_clock, .term_en_input, .term_en_select, .wr_strobe, .rd_strobe,
        .exec_addr, .wr_data, .spi_err, .diag, .own_id, .id_valid);
    ssf_master_model mdl (.serial_clock, .chip_select_n, .serial_in, .serial_out, .serial_out_oe);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Own CRC3 for x^3+x+1, zero start; leading zeros leave it unchanged.
    function automatic logic [2:0] crc(input logic [28:0] m);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 28; i >= 0; i--) c = {c[1:0], 1'b0} ^ ((c[2] ^ m[i]) ? 3'h3 : 3'h0);
        return c;
    endfunction : crc
    function automatic logic [31:0] mk(input logic rw, input logic [1:0] cl, input logic [4:0] id,
                                       input logic [6:0] a, input logic [12:0] d);
        return {rw, cl, id, 1'b0, a, d, crc({rw, cl, id, 1'b0, a, d})};
    endfunction : mk
    task automatic frame(input logic [31:0] f, input int n, input int stall);
        mdl.xfer(f, n, stall, rep, oe_mid);
        repeat (10) @(posedge clk);
    endtask : frame
    task automatic clear();
        @(posedge clk) err_clear <= 1'b1;
        @(posedge clk) err_clear <= 1'b0;
        @(posedge clk);
    endtask : clear
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // Cuts a hang short well after the expected run of about 60 us.
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
    // Main sequence; error frames come from a table of frame, length, stall and flag.
    initial begin
        repeat (19) @(posedge clk);
        check({term_en_select, term_en_input, term_en_clock, spi_err}, 4'hE);
        @(posedge clk) reset_n <= 1'b1;
        repeat (12) @(posedge clk);
        check({id_valid, own_id}, {1'b1, ID});
        w0 = wr_cnt;
        frame(mk(1'b0, 2'h1, ID, 7'h05, 13'h1ABC), 32, 0);
        check({rep[31:24], oe_mid}, 9'h001);
        check(wr_cnt - w0, 1);
        check({exec_addr, wr_data}, {7'h05, 13'h1ABC});
        frame(mk(1'b0, 2'h1, ID, 7'h01, 13'h0002), 32, 0);
        check(rep[23:0], {4'h9, 7'h05, 13'h1ABC});
        check({term_en_select, term_en_input, term_en_clock}, 3'h2);
        r0 = rd_cnt;
        frame(mk(1'b1, 2'h1, ID, 7'h05, 13'h0000), 32, 0);
        check(rep, {9'h000, 7'h5A, 13'h1ABC, crc({9'h000, 7'h5A, 13'h1ABC})});
        check(rd_cnt - r0, 1);
        w0 = wr_cnt;
        frame(mk(1'b0, 2'h1, 5'h0C, 7'h05, 13'h0007), 32, 0);
        check({oe_mid, spi_err, 8'(wr_cnt - w0)}, 10'h000);
        frame(mk(1'b0, 2'h2, 5'h00, 7'h05, 13'h0033), 32, 0);
        check({rep[23:0], wr_data}, {24'h0, 13'h0033});
        ef = '{mk(1'b0, 2'h1, ID, 7'h05, 13'h0001) ^ 32'h1, mk(1'b0, 2'h1, ID, 7'h05, 13'h0001),
               mk(1'b0, 2'h1, ID, 7'h40, 13'h0001), mk(1'b0, 2'h3, ID, 7'h05, 13'h0001),
               mk(1'b1, 2'h1, ID, 7'h05, 13'h0001), mk(1'b0, 2'h1, ID, 7'h05, 13'h0001)};
        en = '{32, 33, 32, 32, 32, 32};
        es = '{0, 0, 0, 0, 0, 15000};
        ed = '{4'h4, 4'h8, 4'h2, 4'h2, 4'h1, 4'h8};
        for (int k = 0; k < 6; k++) begin
            w0 = wr_cnt;
            frame(ef[k], en[k], es[k]);
            check({spi_err, diag}, {1'b1, ed[k]});
            check(wr_cnt - w0, 0);
            frame(mk(1'b1, 2'h1, ID, 7'h05, 13'h0000), 32, 0);
            check(rep[23], 1'b1);
            clear();
        end
        check({spi_err, diag}, 5'h00);
        wrap_up();
    end
endmodule : ssf_frame_slave_tb_top
`default_nettype wire
